/* rtl/cafr_top.sv */
// Cell converter control: configuration, filtering, result registers and Wishbone slave
//
// Summary of operation
// R01: Ratio code 00 gives 32, 214 us
// R02: Ratio code 01 gives 64, 311 us
// R03: Multiplier-free single-pole low-pass after decimation
// R04: Result low-pass input is corrected value; raw low-pass takes uncorrected data
// R05: Filter enabled forces continuous minimum-interval conversions
// R06: Three-bit shift code sets filter corner
// R07: Host allows filter step response settling
// R08: Corrected 16 bits, uncorrected 24 bits, bytewise
// R09: High-byte read freezes middle and low bytes
// R10: Host reads high byte first, burst
// R11: Die temperature sampled, corrects each result
// R12: Raw registers filtered only when both selects
// R13: Results are two's complement counts
// R14: Every start presets results to 0x8000/0x800000
// R15: Channel enable drives level shifter, stays on
// R16: Host waits settle time after enabling
// R17: Start bit begins conversions on enabled channels
// R18: Delay field postpones conversion after start
// R19: Single or continuous with programmed interval
// R20: Separate ratio for aux; die follows cell
// R21: Read before completion returns 0x8000
// R22: State adds shifted input-minus-output difference
// R23: Codes 10 and 11 give 128, 256
`timescale 1ns/100ps
module cafr_top #(
  parameter int NCELL            = 6,
  parameter int unsigned CYC_DR0 = cafr_pkg::CONV_US_DR32 * cafr_pkg::CLK_MHZ,
  parameter int unsigned CYC_DR1 = cafr_pkg::CONV_US_DR64 * cafr_pkg::CLK_MHZ,
  parameter int unsigned CYC_DR2 = cafr_pkg::CONV_US_DR128 * cafr_pkg::CLK_MHZ,
  parameter int unsigned CYC_DR3 = cafr_pkg::CONV_US_DR256 * cafr_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Decimation filter data
  input  wire logic [NCELL*24-1:0] raw_data,
  input  wire logic [15:0]         die_temp,
  // Converter control
  output logic      [NCELL-1:0]    level_shift_en,
  output logic      [1:0]          cell_ratio,
  output logic      [1:0]          aux_ratio,
  output logic                     conv_start,
  output logic                     conv_busy
);
  import cafr_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [4:0]       conf1_reg,   conf1_next;
  logic [1:0]       aux_reg,     aux_next;
  logic [1:0]       diag_reg,    diag_next;
  logic [NCELL-1:0] chan_reg,    chan_next;
  logic [7:0]       conf2_reg,   conf2_next;
  logic [7:0]       delay_reg,   delay_next;
  logic             go_reg,      go_next;
  logic             drdy_reg,    drdy_next;
  logic [NCELL-1:0] en_cap_reg,  en_cap_next;
  logic             ack_next;
  logic [31:0]      rd_next;
  logic             acc, wr, rd;
  logic [1:0]       decimation_ratio_sel;
  logic [2:0]       lowpass_shift_sel;
  logic             filter_route_select, uncorrected_route_select;
  logic             seq_busy, seq_start, seq_done, done_d;

  assign acc                      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr                       = acc && wb_we_i && wb_sel_i[0];
  assign rd                       = acc && !wb_we_i;
  assign decimation_ratio_sel     = conf1_reg[DR_LSB +: 2];
  assign lowpass_shift_sel        = conf1_reg[SHIFT_LSB +: 3];
  assign filter_route_select      = diag_reg[FILT_ROUTE];
  assign uncorrected_route_select = diag_reg[UNCORR_ROUTE];

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  logic [15:0] corr_reg  [NCELL], corr_next  [NCELL];
  logic [7:0]  corr_lo_q [NCELL], corr_lo_nx [NCELL];
  logic [15:0] filt_reg  [NCELL], filt_next  [NCELL];
  logic [7:0]  filt_lo_q [NCELL], filt_lo_nx [NCELL];
  logic [23:0] raw_reg   [NCELL], raw_next   [NCELL];
  logic [15:0] raw_lo_q  [NCELL], raw_lo_nx  [NCELL];
  logic [15:0] corr_val  [NCELL];
  logic [15:0] lpf_out   [NCELL];
  logic [23:0] lpf_raw   [NCELL];
  logic [15:0] die_reg,  die_next;
  logic [7:0]  die_lo_q, die_lo_nx;
  logic [2:0]  rch;
  logic        res_hit;

  function automatic logic [15:0] correct(input logic [23:0] raw, input logic [15:0] die);
    logic signed [16:0] sum;
    sum = $signed({raw[23], raw[23:8]}) - $signed(17'($signed(die) >>> TCORR_SHIFT));
    if (sum > 17'sh0_7FFF) begin
      correct = 16'h7FFF;
    end else if (sum < -17'sh0_7FFF) begin
      correct = 16'h8001;
    end else begin
      correct = sum[15:0];
    end
  endfunction

  for (genvar c = 0; c < NCELL; c++) begin : g_ch
    assign corr_val[c] = correct(raw_data[c*24 +: 24], die_temp); // R11 R13
    cafr_lpf #(.W(16)) u_lpf (
      .sys_clk (sys_clk),
      .rst     (rst),
      .sample  (seq_done && en_cap_reg[c]),
      .shift   (lowpass_shift_sel),
      .x       (corr_val[c]), // R04
      .y       (lpf_out[c])
    );
    cafr_lpf #(.W(24)) u_lpf_raw (
      .sys_clk (sys_clk),
      .rst     (rst),
      .sample  (seq_done && en_cap_reg[c]),
      .shift   (lowpass_shift_sel),
      .x       (raw_data[c*24 +: 24]),
      .y       (lpf_raw[c])
    );
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  cafr_seq #(
    .CYC_DR0 (CYC_DR0),
    .CYC_DR1 (CYC_DR1),
    .CYC_DR2 (CYC_DR2),
    .CYC_DR3 (CYC_DR3)
  ) u_seq (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .go          (go_reg), // R17
    .cont        (conf2_reg[CONT_BIT] || filter_route_select), // R05
    .interval_us (filter_route_select ? 7'h00 : conf2_reg[INT_LSB +: 7]), // R05
    .delay_us    (delay_reg),
    .dr          (decimation_ratio_sel),
    .busy        (seq_busy),
    .conv_start  (seq_start),
    .conv_done   (seq_done)
  );

  // ----------------------------------------------------------------
  // Register and result next state
  // ----------------------------------------------------------------
  always_comb begin
    rch         = wb_adr_i[7:5] - RES_CH_BASE;
    res_hit     = (wb_adr_i[7:5] >= RES_CH_BASE) && (32'(rch) < NCELL);
    conf1_next  = conf1_reg;
    aux_next    = aux_reg;
    diag_next   = diag_reg;
    chan_next   = chan_reg;
    conf2_next  = conf2_reg;
    delay_next  = delay_reg;
    go_next     = 1'b0;
    en_cap_next = en_cap_reg;
    die_next    = die_reg;
    die_lo_nx   = die_lo_q;
    if (wr) begin
      case (wb_adr_i)
        OFS_CELL_CONF1: conf1_next = wb_dat_i[4:0]; // R06
        OFS_AUX_CONF:   aux_next   = wb_dat_i[1:0]; // R20
        OFS_DIAG4:      diag_next  = wb_dat_i[1:0];
        OFS_CHAN_CTRL:  chan_next  = wb_dat_i[NCELL-1:0]; // R15
        OFS_CONF2:      conf2_next = wb_dat_i[7:0];
        OFS_DELAY:      delay_next = wb_dat_i[7:0]; // R18
        OFS_CMD2:       go_next    = wb_dat_i[GO_BIT];
        default: begin
        end
      endcase
    end
    if (go_reg) begin
      en_cap_next = chan_reg; // R17
      die_next    = PRESET16;
      die_lo_nx   = PRESET16[7:0];
    end else if (seq_done) begin
      die_next = die_temp; // R11 R20
    end
    drdy_next = (drdy_reg && !go_reg) || done_d;
    if (rd && wb_adr_i == OFS_DIE_HIGH) begin
      die_lo_nx = die_reg[7:0]; // R09
    end
    for (int c = 0; c < NCELL; c++) begin
      corr_next[c]  = corr_reg[c];
      filt_next[c]  = filt_reg[c];
      raw_next[c]   = raw_reg[c];
      corr_lo_nx[c] = corr_lo_q[c];
      filt_lo_nx[c] = filt_lo_q[c];
      raw_lo_nx[c]  = raw_lo_q[c];
      if (go_reg) begin
        corr_next[c]  = PRESET16; // R14 R21
        filt_next[c]  = PRESET16; // R14
        raw_next[c]   = PRESET24; // R14
        corr_lo_nx[c] = PRESET16[7:0];
        filt_lo_nx[c] = PRESET16[7:0];
        raw_lo_nx[c]  = PRESET24[15:0];
      end else begin
        if (seq_done && en_cap_reg[c]) begin
          corr_next[c] = corr_val[c]; // R08
          if (!(filter_route_select && uncorrected_route_select)) begin
            raw_next[c] = raw_data[c*24 +: 24]; // R12
          end
        end
        if (done_d && en_cap_reg[c]) begin
          filt_next[c] = lpf_out[c];
          if (filter_route_select && uncorrected_route_select) begin
            raw_next[c] = lpf_raw[c]; // R12
          end
        end
        if (rd && res_hit && 32'(rch) == c) begin
          case (wb_adr_i[4:0])
            RES_CORR_HIGH: corr_lo_nx[c] = corr_reg[c][7:0]; // R09 R10
            RES_FILT_HIGH: filt_lo_nx[c] = filt_reg[c][7:0]; // R09 R10
            RES_RAW_HIGH:  raw_lo_nx[c]  = raw_reg[c][15:0]; // R09 R10
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    rd_next  = 32'h0000_0000;
    ack_next = acc;
    case (wb_adr_i)
      OFS_CELL_CONF1: rd_next = 32'(conf1_reg);
      OFS_AUX_CONF:   rd_next = 32'(aux_reg);
      OFS_DIAG4:      rd_next = 32'(diag_reg);
      OFS_CHAN_CTRL:  rd_next = 32'(chan_reg);
      OFS_CONF2:      rd_next = 32'(conf2_reg);
      OFS_DELAY:      rd_next = 32'(delay_reg);
      OFS_STATUS:     rd_next = 32'({drdy_reg, seq_busy});
      OFS_DIE_HIGH:   rd_next = 32'(die_reg[15:8]);
      OFS_DIE_LOW:    rd_next = 32'(die_lo_q);
      default: begin
        if (res_hit) begin
          case (wb_adr_i[4:0])
            RES_CORR_HIGH: rd_next = 32'(corr_reg[rch][15:8]);
            RES_CORR_LOW:  rd_next = 32'(corr_lo_q[rch]);
            RES_FILT_HIGH: rd_next = 32'(filt_reg[rch][15:8]);
            RES_FILT_LOW:  rd_next = 32'(filt_lo_q[rch]);
            RES_RAW_HIGH:  rd_next = 32'(raw_reg[rch][23:16]);
            RES_RAW_MID:   rd_next = 32'(raw_lo_q[rch][15:8]);
            RES_RAW_LOW:   rd_next = 32'(raw_lo_q[rch][7:0]);
            default:       rd_next = 32'h0000_0000;
          endcase
        end
      end
    endcase
    if (!rd) begin
      rd_next = wb_dat_o;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conf1_reg      <= {SHIFT_RST, DR_RST};
      aux_reg        <= DR_RST;
      diag_reg       <= 2'h0;
      chan_reg       <= '0;
      conf2_reg      <= 8'h00;
      delay_reg      <= 8'h00;
      go_reg         <= 1'b0;
      drdy_reg       <= 1'b0;
      en_cap_reg     <= '0;
      done_d         <= 1'b0;
      die_reg        <= PRESET16;
      die_lo_q       <= PRESET16[7:0];
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0000_0000;
      level_shift_en <= '0;
      cell_ratio     <= DR_RST;
      aux_ratio      <= DR_RST;
      conv_start     <= 1'b0;
      conv_busy      <= 1'b0;
      for (int c = 0; c < NCELL; c++) begin
        corr_reg[c]  <= PRESET16;
        filt_reg[c]  <= PRESET16;
        raw_reg[c]   <= PRESET24;
        corr_lo_q[c] <= PRESET16[7:0];
        filt_lo_q[c] <= PRESET16[7:0];
        raw_lo_q[c]  <= PRESET24[15:0];
      end
    end else begin
      conf1_reg      <= conf1_next;
      aux_reg        <= aux_next;
      diag_reg       <= diag_next;
      chan_reg       <= chan_next;
      conf2_reg      <= conf2_next;
      delay_reg      <= delay_next;
      go_reg         <= go_next;
      drdy_reg       <= drdy_next;
      en_cap_reg     <= en_cap_next;
      done_d         <= seq_done && !go_reg;
      die_reg        <= die_next;
      die_lo_q       <= die_lo_nx;
      wb_ack_o       <= ack_next;
      wb_dat_o       <= rd_next;
      level_shift_en <= chan_next; // R15
      cell_ratio     <= conf1_next[DR_LSB +: 2];
      aux_ratio      <= aux_next; // R20
      conv_start     <= seq_start;
      conv_busy      <= seq_busy;
      for (int c = 0; c < NCELL; c++) begin
        corr_reg[c]  <= corr_next[c];
        filt_reg[c]  <= filt_next[c];
        raw_reg[c]   <= raw_next[c];
        corr_lo_q[c] <= corr_lo_nx[c];
        filt_lo_q[c] <= filt_lo_nx[c];
        raw_lo_q[c]  <= raw_lo_nx[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ACK_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_PRESET: assert property (@(posedge sys_clk) disable iff (rst) // R14
    go_reg |=> corr_reg[0] == PRESET16 && raw_reg[0] == PRESET24 && filt_reg[0] == PRESET16)
    else $error("results not preset on start");
  AST_LOCK: assert property (@(posedge sys_clk) disable iff (rst) // R09
    rd && !go_reg && wb_adr_i == {RES_CH_BASE, RES_RAW_HIGH} |=> raw_lo_q[0] == $past(raw_reg[0][15:0]))
    else $error("high read did not freeze lower bytes");
  AST_ROUTE: assert property (@(posedge sys_clk) disable iff (rst) // R12
    done_d && !go_reg && en_cap_reg[0] && !(filter_route_select && uncorrected_route_select)
    |-> raw_reg[0] == $past(raw_data[23:0]))
    else $error("raw register carries wrong route");
  AST_SHIFTER: assert property (@(posedge sys_clk) disable iff (rst) // R15
    wr && wb_adr_i == OFS_CHAN_CTRL |=> level_shift_en == $past(wb_dat_i[NCELL-1:0]))
    else $error("level shifter enable does not follow channel control");
  // Helper: filter select as captured by the last start
  logic filt_go_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt_go_reg <= 1'b0;
    end else if (go_reg) begin
      filt_go_reg <= filter_route_select;
    end
  end

  AST_FILT_CONT: assert property (@(posedge sys_clk) disable iff (rst) // R05
    seq_done && filt_go_reg && !go_reg |=> seq_busy [*3])
    else $error("filter mode did not continue conversions");
  AST_DRDY: assert property (@(posedge sys_clk) disable iff (rst) // R21
    go_reg && !done_d |=> !drdy_reg until_with corr_reg[0] != PRESET16 || done_d)
    else $error("ready flagged before results updated");
endmodule // cafr_top

/* rtl/cafr_pkg.sv */
// Package: register map, field layout and timing constants of the cell converter control
package cafr_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CELL_CONF1 = 8'h00;
  localparam logic [7:0] OFS_AUX_CONF   = 8'h04;
  localparam logic [7:0] OFS_DIAG4      = 8'h08;
  localparam logic [7:0] OFS_CHAN_CTRL  = 8'h0C;
  localparam logic [7:0] OFS_CONF2      = 8'h10;
  localparam logic [7:0] OFS_DELAY      = 8'h14;
  localparam logic [7:0] OFS_CMD2       = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1C;
  localparam logic [7:0] OFS_DIE_HIGH   = 8'h20;
  localparam logic [7:0] OFS_DIE_LOW    = 8'h24;
  // Result block: channel n at 0x40 + n*0x20
  localparam logic [2:0] RES_CH_BASE    = 3'h2;
  localparam logic [4:0] RES_CORR_HIGH  = 5'h00;
  localparam logic [4:0] RES_CORR_LOW   = 5'h04;
  localparam logic [4:0] RES_FILT_HIGH  = 5'h08;
  localparam logic [4:0] RES_FILT_LOW   = 5'h0C;
  localparam logic [4:0] RES_RAW_HIGH   = 5'h10;
  localparam logic [4:0] RES_RAW_MID    = 5'h14;
  localparam logic [4:0] RES_RAW_LOW    = 5'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DR_LSB        = 0;
  localparam int SHIFT_LSB     = 2;
  localparam int FILT_ROUTE    = 0;
  localparam int UNCORR_ROUTE  = 1;
  localparam int CONT_BIT      = 0;
  localparam int INT_LSB       = 1;
  localparam int GO_BIT        = 0;
  // ----------------------------------------------------------------
  // Reset and preset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PRESET16   = 16'h8000;
  localparam logic [23:0] PRESET24   = 24'h80_0000;
  localparam logic [1:0]  DR_RST     = 2'h0;
  localparam logic [2:0]  SHIFT_RST  = 3'h0;
  localparam int          LPF_FRAC   = 8;
  localparam logic [2:0]  LPF_BASE   = 3'h1;
  localparam int          TCORR_SHIFT = 6;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned CONV_US_DR32  = 214;
  localparam int unsigned CONV_US_DR64  = 311;
  localparam int unsigned CONV_US_DR128 = 503;
  localparam int unsigned CONV_US_DR256 = 887;
  localparam logic [6:0]  US_TICK_LAST = 7'(CLK_MHZ - 1);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_GAP} cafr_seq_e;
endpackage

/* rtl/cafr_lpf.sv */
// Shift-based single-pole low-pass stage
`timescale 1ns/100ps
module cafr_lpf #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Sample in
  input  wire logic         sample,
  input  wire logic [2:0]   shift,
  input  wire logic [W-1:0] x,
  // Filtered out
  output logic      [W-1:0] y
);
  import cafr_pkg::*;

  logic signed [W+LPF_FRAC-1:0] s_reg;
  logic signed [W+LPF_FRAC-1:0] s_next;
  logic signed [W+LPF_FRAC:0]   diff;

  always_comb begin
    diff   = $signed({x[W-1], x, {LPF_FRAC{1'b0}}}) - $signed({s_reg[W+LPF_FRAC-1], s_reg});
    s_next = s_reg;
    if (sample) begin
      // Four-bit sum: code 7 plus base must reach 8, not wrap to 0
      s_next = s_reg + (W+LPF_FRAC)'(diff >>> (4'(shift) + 4'(LPF_BASE))); // R22 R03
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign y = s_reg[W+LPF_FRAC-1:LPF_FRAC];
endmodule // cafr_lpf

/* rtl/cafr_seq.sv */
// Conversion sequencer: start delay, conversion time and continuous interval
`timescale 1ns/100ps
module cafr_seq #(
  parameter int unsigned CYC_DR0 = 26750,
  parameter int unsigned CYC_DR1 = 38875,
  parameter int unsigned CYC_DR2 = 62875,
  parameter int unsigned CYC_DR3 = 110875
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       go,
  input  wire logic       cont,
  input  wire logic [6:0] interval_us,
  input  wire logic [7:0] delay_us,
  input  wire logic [1:0] dr,
  // Status
  output logic            busy,
  output logic            conv_start,
  output logic            conv_done
);
  import cafr_pkg::*;

  cafr_seq_e   st_reg,   st_next;
  logic [6:0]  tick_reg, tick_next;
  logic [16:0] cnt_reg,  cnt_next;
  logic        cont_reg, cont_next;
  logic [6:0]  int_reg,  int_next;
  logic [1:0]  dr_reg,   dr_next;
  logic        start_next, done_next;
  logic        tick;

  function automatic logic [16:0] conv_len(input logic [1:0] code);
    case (code)
      2'h0:    conv_len = 17'(CYC_DR0 - 1); // R01
      2'h1:    conv_len = 17'(CYC_DR1 - 1); // R02
      2'h2:    conv_len = 17'(CYC_DR2 - 1); // R23
      default: conv_len = 17'(CYC_DR3 - 1); // R23
    endcase
  endfunction

  always_comb begin
    tick       = (tick_reg == US_TICK_LAST);
    tick_next  = tick ? 7'h00 : tick_reg + 7'h01;
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    cont_next  = cont_reg;
    int_next   = int_reg;
    dr_next    = dr_reg;
    start_next = 1'b0;
    done_next  = 1'b0;
    case (st_reg)
      ST_DELAY, ST_GAP: begin
        if (tick) begin
          if (cnt_reg == 17'h0_0000) begin
            st_next    = ST_CONV;
            cnt_next   = conv_len(dr_reg);
            start_next = 1'b1;
          end else begin
            cnt_next = cnt_reg - 17'h0_0001;
          end
        end
      end
      ST_CONV: begin
        if (cnt_reg == 17'h0_0000) begin
          done_next = 1'b1;
          if (cont_reg) begin // R19
            st_next  = ST_GAP;
            cnt_next = 17'(int_reg);
          end else begin
            st_next = ST_IDLE;
          end
        end else begin
          cnt_next = cnt_reg - 17'h0_0001;
        end
      end
      default: begin
      end
    endcase
    // A new start aborts any running conversion
    if (go) begin
      cont_next = cont;
      int_next  = interval_us;
      dr_next   = dr;
      done_next = 1'b0;
      if (delay_us == 8'h00) begin
        st_next    = ST_CONV;
        cnt_next   = conv_len(dr);
        start_next = 1'b1;
      end else begin
        st_next    = ST_DELAY; // R18
        cnt_next   = 17'(delay_us);
        start_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg     <= ST_IDLE;
      tick_reg   <= 7'h00;
      cnt_reg    <= 17'h0_0000;
      cont_reg   <= 1'b0;
      int_reg    <= 7'h00;
      dr_reg     <= DR_RST;
      conv_start <= 1'b0;
      conv_done  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      tick_reg   <= tick_next;
      cnt_reg    <= cnt_next;
      cont_reg   <= cont_next;
      int_reg    <= int_next;
      dr_reg     <= dr_next;
      conv_start <= start_next;
      conv_done  <= done_next;
    end
  end

  assign busy = (st_reg != ST_IDLE);

  // Helper: cycles since the last conversion start
  logic [16:0] run_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst || start_next) begin
      run_cnt <= 17'h0_0000;
    end else begin
      run_cnt <= run_cnt + 17'h0_0001;
    end
  end

  AST_CONV_TIME: assert property (@(posedge sys_clk) disable iff (rst) // R01
    conv_done |-> run_cnt == 17'(conv_len(dr_reg) + 17'h0_0001))
    else $error("conversion length does not match ratio");
  AST_DELAY_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R18
    go && delay_us != 8'h00 |=> !conv_start [*8])
    else $error("conversion began before start delay");
endmodule // cafr_seq

/* sim/test_cafr_top.sv */
// Testbench for the cell converter control block
`timescale 1ns/100ps
module test_cafr_top;
  import cafr_pkg::*;
  localparam int NC = 6;
  localparam int CYC [4] = '{40, 60, 80, 100};
  localparam logic [7:0] RA [5] = '{8'h40, 8'h44, 8'h50, 8'h54, 8'h58};
  localparam logic [7:0] RE [5] = '{8'h12, 8'h33, 8'h12, 8'h34, 8'h56};
  // Settled filter outputs sit one LSB below their input (state one fraction step below)
  localparam logic [7:0] FA [5] = '{8'h48, 8'h4C, 8'h50, 8'h54, 8'h58};
  localparam logic [7:0] FE [5] = '{8'h12, 8'h32, 8'h12, 8'h34, 8'h55};
  logic             sys_clk  = 1'b0;
  logic             rst      = 1'b1;
  logic             wb_cyc_i = 1'b0;
  logic             wb_stb_i = 1'b0;
  logic             wb_we_i  = 1'b0;
  logic [7:0]       wb_adr_i = 8'h00;
  logic [3:0]       wb_sel_i = 4'h0;
  logic [31:0]      wb_dat_i = 32'h0000_0000;
  logic [NC*24-1:0] raw_data = {NC{24'h12_3456}};
  logic [15:0]      die_temp = 16'h0040;
  logic [31:0]      wb_dat_o, q;
  logic             wb_ack_o, conv_start, conv_busy;
  logic [NC-1:0]    level_shift_en;
  logic [1:0]       cell_ratio, aux_ratio;
  int               n_errors = 0, total_checks = 0, n, k, dur [4];

  cafr_top #(.NCELL(NC), .CYC_DR0(CYC[0]), .CYC_DR1(CYC[1]), .CYC_DR2(CYC[2]), .CYC_DR3(CYC[3])) u_cafr_top (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .raw_data(raw_data), .die_temp(die_temp), .level_shift_en(level_shift_en),
    .cell_ratio(cell_ratio), .aux_ratio(aux_ratio), .conv_start(conv_start), .conv_busy(conv_busy));

  always #4 sys_clk = ~sys_clk;

  task print_verdict;
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic Wishbone cycle; read data lands in q
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 40) begin n_errors++; print_verdict; end
  endtask

  task wait_start(output int c);
    for (c = 0; c < 2000; c++) begin
      @(posedge sys_clk);
      if (conv_start === 1'b1) break;
    end
    if (c == 2000) begin n_errors++; print_verdict; end
  endtask

  task wait_idle(output int c);
    for (c = 0; c < 2000; c++) begin
      @(posedge sys_clk);
      if (conv_busy === 1'b0) break;
    end
    if (c == 2000) begin n_errors++; print_verdict; end
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    wb(1'b0, 8'h40, 32'h0000_0000); check(q, 32'h0000_0080);
    wb(1'b1, OFS_CHAN_CTRL, 32'h0000_003F); check({26'h0, level_shift_en}, 32'h0000_003F);
    repeat (8) @(posedge sys_clk);
    wb(1'b1, OFS_AUX_CONF, 32'h0000_0001); check({30'h0, aux_ratio}, 32'h0000_0001);
    // Conversion length per ratio code, relative to code 0
    for (k = 0; k < 4; k++) begin
      wb(1'b1, OFS_CELL_CONF1, 32'(k)); check({30'h0, cell_ratio}, 32'(k));
      wb(1'b1, OFS_CMD2, 32'h0000_0001);
      wait_start(n);
      wait_idle(dur[k]);
      if (k > 0) check(32'(dur[k] - dur[0]), 32'(CYC[k] - CYC[0]));
    end
    repeat (4) @(posedge sys_clk);
    wb(1'b0, OFS_STATUS, 32'h0000_0000); check(q, 32'h0000_0002);
    for (k = 0; k < 5; k++) begin
      wb(1'b0, RA[k], 32'h0000_0000); check(q, {24'h0, RE[k]});
    end
    wb(1'b0, OFS_DIE_HIGH, 32'h0000_0000); check(q, 32'h0000_0000);
    wb(1'b0, OFS_DIE_LOW, 32'h0000_0000); check(q, 32'h0000_0040);
    // Delayed start presets results first
    wb(1'b1, OFS_DELAY, 32'h0000_0003);
    wb(1'b1, OFS_CMD2, 32'h0000_0001);
    wb(1'b0, 8'h40, 32'h0000_0000); check(q, 32'h0000_0080);
    wb(1'b0, 8'h54, 32'h0000_0000); check(q, 32'h0000_0000);
    wait_start(n); check({31'h0, n > 3 * CLK_MHZ - 10 && n < 4 * CLK_MHZ}, 32'h0000_0001);
    wait_idle(n);
    // Continuous mode, zero interval
    wb(1'b1, OFS_DELAY, 32'h0000_0000);
    wb(1'b1, OFS_CONF2, 32'h0000_0001);
    wb(1'b1, OFS_CMD2, 32'h0000_0001);
    wait_start(n);
    wait_start(n); check({31'h0, n >= CYC[3] && n < CYC[3] + CLK_MHZ}, 32'h0000_0001);
    // Stop continuous mode, then let filter select force it
    wb(1'b1, OFS_CONF2, 32'h0000_0000);
    wb(1'b1, OFS_CMD2, 32'h0000_0001);
    wait_idle(n);
    wb(1'b1, OFS_DIAG4, 32'h0000_0003);
    wb(1'b1, OFS_CMD2, 32'h0000_0001);
    wait_start(n);
    wait_start(n); check({31'h0, n >= CYC[3] && n < CYC[3] + CLK_MHZ}, 32'h0000_0001);
    for (k = 0; k < 40; k++) begin
      wait_start(n);
    end
    for (k = 0; k < 5; k++) begin
      wb(1'b0, FA[k], 32'h0000_0000); check(q, {24'h0, FE[k]});
    end
    print_verdict;
  end
endmodule // test_cafr_top
